// ---- verilog/src_pkg.sv ----
// srcpkg: constants and types for the spi role and interrupt control block
// assumes a byte-addressed 32-bit register bus and a sampled serial link
package src_pkg;

  localparam int          DW        = 32;
  localparam int          AW        = 8;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL  = 8'h38;
  localparam logic [7:0]  OFS_STAT  = 8'h50;
  localparam logic [7:0]  OFS_CLR   = 8'h54;
  localparam logic [7:0]  OFS_EN    = 8'h58;
  localparam logic [7:0]  OFS_CFG   = 8'h5c;
  // control register field positions
  localparam int          B_LCLR    = 31;
  localparam int          B_SLAVE   = 30;
  localparam int          B_BUFEN   = 29;
  localparam int          B_STAEN   = 28;
  localparam int          CNT_LSB   = 23;
  localparam int          CNT_W     = 4;
  localparam int          ST_LSB    = 20;
  localparam int          ST_W      = 3;
  localparam int          EN_LSB    = 5;
  localparam int          RAW_LSB   = 0;
  localparam int          NIRQ      = 5;
  localparam int          B_HD      = 0;
  // interrupt bit indices
  localparam int          I_DONE    = 0;
  localparam int          I_SWR     = 1;
  localparam int          I_SRD     = 2;
  localparam int          I_BWR     = 3;
  localparam int          I_BRD     = 4;
  // half-duplex command codes
  localparam logic [7:0]  CMD_SWR   = 8'h01;
  localparam logic [7:0]  CMD_BWR   = 8'h02;
  localparam logic [7:0]  CMD_BRD   = 8'h03;
  localparam logic [7:0]  CMD_SRD   = 8'h04;
  localparam logic [2:0]  CMD_LAST  = 3'h7;
  // serial state codes shown to software
  localparam logic [2:0]  STC_IDLE  = 3'h0;
  localparam logic [2:0]  STC_CMD   = 3'h2;
  localparam logic [2:0]  STC_RD    = 3'h4;
  localparam logic [2:0]  STC_WR    = 3'h5;
  localparam logic [2:0]  STC_WAIT  = 3'h6;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } src_pins_t;

  localparam src_pins_t   PIN_IDLE  = 3'h2;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_CMD  = 4'b0010,
    S_DATA = 4'b0100,
    S_SKIP = 4'b1000
  } src_state_t;

endpackage : src_pkg

// ---- verilog/src_core.sv ----
// srccore: role select, line-latch clear, slave half-duplex command gate,
// operation counter, serial state readback and interrupt flags
// assumes an avalon-mm master on mclk and an spi master/slave on the pins
//
// Overview of operation
// R01: line-latch clear bit holds the sampled sck, cs and data lines at idle
// R02: role bit selects slave when 1 and master when 0, read-write
// R03: buffer commands accepted in slave half-duplex only while buffer enable set
// R04: status commands accepted in slave half-duplex only while status enable set
// R05: read-only counter of completed operations in both roles
// R06: slave role shows serial state machine state in a read-only field
// R07: five read-write interrupt enable bits
// R08: transfer-done flag set on completion, stays until software clears it
// R09: status write/read flags set on completed status commands, software clears
// R10: buffer write/read flags set on completed buffer commands, software clears
// R11: each interrupt request is high while its flag and enable are set
// R12: control register reads zero after reset: master role, interrupts off
`timescale 1ns/1ps
module src_core
  import src_pkg::*;
(
  input  logic                mclk,
  input  logic                sys_rst,
  input  logic [AW-1:0]       avs_address,
  input  logic                avs_read,
  input  logic                avs_write,
  input  logic [DW-1:0]       avs_writedata,
  output logic [DW-1:0]       avs_readdata,
  output logic                avs_waitrequest,
  input  src_pins_t           spi_in,
  output logic                spi_miso,
  output logic                spi_miso_oe,
  input  logic                mst_op_done,
  output logic                slave_mode,
  output logic [NIRQ-1:0]     irq_req,
  output logic                irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic                lclr_q,  lclr_d;
  logic                slave_q, slave_d;
  logic                bufen_q, bufen_d;
  logic                staen_q, staen_d;
  logic                hd_q,    hd_d;
  logic [NIRQ-1:0]     en_q,    en_d;
  logic [NIRQ-1:0]     raw_q,   raw_d;
  logic [CNT_W-1:0]    cnt_q,   cnt_d;
  logic                ack_q,   ack_d;
  logic [DW-1:0]       rdat_q,  rdat_d;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  src_pins_t           s1_q, s1_d;
  src_pins_t           s2_q, s2_d;
  src_pins_t           s3_q, s3_d;
  src_pins_t           f_q,  f_d;
  logic                sck_rise;
  logic                sck_fall;
  logic                cs_fall;
  logic                cs_rise;

  always_comb begin
    s1_d = spi_in;
    s2_d = s1_q;
    s3_d = s2_q;
    // a change counts only once stages two and three agree
    f_d  = (s2_q == s3_q) ? s2_q : f_q;
    // R01 latch clear
    if (lclr_q) begin
      s1_d = PIN_IDLE;
      s2_d = PIN_IDLE;
      s3_d = PIN_IDLE;
      f_d  = PIN_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
      f_q  <= PIN_IDLE;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      f_q  <= f_d;
    end
  end

  assign sck_rise = ~f_q.sck & f_d.sck & ~f_d.cs_n;
  assign sck_fall = f_q.sck & ~f_d.sck & ~f_d.cs_n;
  assign cs_fall  = f_q.cs_n & ~f_d.cs_n;
  assign cs_rise  = ~f_q.cs_n & f_d.cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // slave serial state machine
  src_state_t          st_q,   st_d;
  logic [2:0]          bit_q,  bit_d;
  logic [7:0]          sh_q,   sh_d;
  logic [NIRQ-1:0]     hit_q,  hit_d;
  logic                rd_q,   rd_d;
  logic                seen_q, seen_d;
  logic [7:0]          tx_q,   tx_d;
  logic                miso_q, miso_d;
  logic [7:0]          cmd;
  logic [NIRQ-1:0]     done_set;
  logic                op_done;
  logic [ST_W-1:0]     st_code;

  assign cmd = {sh_q[6:0], f_d.mosi};

  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    hit_d    = hit_q;
    rd_d     = rd_q;
    seen_d   = seen_q;
    tx_d     = tx_q;
    miso_d   = miso_q;
    done_set = '0;
    op_done  = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (slave_q && cs_fall) begin
          bit_d  = '0;
          hit_d  = '0;
          rd_d   = 1'b0;
          seen_d = 1'b0;
          miso_d = 1'b0;
          st_d   = hd_q ? S_CMD : S_DATA;
        end
      end
      S_CMD: begin
        if (sck_rise) begin
          sh_d  = cmd;
          bit_d = bit_q + 3'h1;
          if (bit_q == CMD_LAST) begin
            st_d = S_SKIP;
            // R04 status gate
            if (staen_q && cmd == CMD_SWR) begin
              hit_d[I_SWR] = 1'b1;
              st_d         = S_DATA;
            end
            if (staen_q && cmd == CMD_SRD) begin
              hit_d[I_SRD] = 1'b1;
              rd_d         = 1'b1;
              st_d         = S_DATA;
            end
            // R03 buffer gate
            if (bufen_q && cmd == CMD_BWR) begin
              hit_d[I_BWR] = 1'b1;
              st_d         = S_DATA;
            end
            if (bufen_q && cmd == CMD_BRD) begin
              hit_d[I_BRD] = 1'b1;
              rd_d         = 1'b1;
              st_d         = S_DATA;
            end
            tx_d = {{(8-NIRQ){1'b0}}, raw_q};
          end
        end
      end
      S_DATA: begin
        if (sck_rise) begin
          seen_d = 1'b1;
        end
        // read data leaves on the falling edge so the master samples it stable
        if (sck_fall && rd_q) begin
          miso_d = tx_q[7];
          tx_d   = {tx_q[6:0], 1'b0};
        end
      end
      S_SKIP: begin
        st_d = S_SKIP;
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    if (st_q != S_IDLE && cs_rise) begin
      st_d = S_IDLE;
      rd_d = 1'b0;
      // R09 R10 command flags
      if (st_q == S_DATA && seen_q) begin
        done_set         = hit_q;
        done_set[I_DONE] = 1'b1;
        op_done          = 1'b1;
      end
    end
    // a frame cut short by a role change is dropped, not completed
    if (!slave_q) begin
      st_d = S_IDLE;
      rd_d = 1'b0;
    end
    // R08 master completion
    if (!slave_q && mst_op_done) begin
      done_set[I_DONE] = 1'b1;
      op_done          = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q   <= S_IDLE;
      bit_q  <= '0;
      sh_q   <= '0;
      hit_q  <= '0;
      rd_q   <= 1'b0;
      seen_q <= 1'b0;
      tx_q   <= '0;
      miso_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      hit_q  <= hit_d;
      rd_q   <= rd_d;
      seen_q <= seen_d;
      tx_q   <= tx_d;
      miso_q <= miso_d;
    end
  end

  // R06 state readback
  always_comb begin
    case (st_q)
      S_CMD:   st_code = STC_CMD;
      S_DATA:  st_code = rd_q ? STC_RD : STC_WR;
      S_SKIP:  st_code = STC_WAIT;
      default: st_code = STC_IDLE;
    endcase
    if (!slave_q) begin
      st_code = STC_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle per access, read data ready when it drops
  logic                req;
  logic                wr_go;
  logic [DW-1:0]       ctrl_rd;
  logic [NIRQ-1:0]     wclr;

  assign req   = avs_read | avs_write;
  assign wr_go = avs_write & ack_q;

  always_comb begin
    ctrl_rd                          = '0;
    ctrl_rd[B_LCLR]                  = lclr_q;
    ctrl_rd[B_SLAVE]                 = slave_q;
    ctrl_rd[B_BUFEN]                 = bufen_q;
    ctrl_rd[B_STAEN]                 = staen_q;
    // R05 counter readback
    ctrl_rd[CNT_LSB +: CNT_W]        = cnt_q;
    ctrl_rd[ST_LSB +: ST_W]          = st_code;
    ctrl_rd[EN_LSB +: NIRQ]          = en_q;
    ctrl_rd[RAW_LSB +: NIRQ]         = raw_q;
  end

  always_comb begin
    ack_d   = req & ~ack_q;
    rdat_d  = rdat_q;
    lclr_d  = lclr_q;
    slave_d = slave_q;
    bufen_d = bufen_q;
    staen_d = staen_q;
    hd_d    = hd_q;
    en_d    = en_q;
    cnt_d   = cnt_q;
    wclr    = '0;
    if (avs_read && !ack_q) begin
      case (avs_address)
        OFS_CTRL: rdat_d = ctrl_rd;
        OFS_STAT: rdat_d = {{(DW-NIRQ){1'b0}}, raw_q};
        OFS_EN:   rdat_d = {{(DW-NIRQ){1'b0}}, en_q};
        OFS_CFG:  rdat_d = {{(DW-1){1'b0}}, hd_q};
        default:  rdat_d = '0;
      endcase
    end
    if (wr_go) begin
      case (avs_address)
        OFS_CTRL: begin
          lclr_d  = avs_writedata[B_LCLR];
          // R02 role select
          slave_d = avs_writedata[B_SLAVE];
          bufen_d = avs_writedata[B_BUFEN];
          staen_d = avs_writedata[B_STAEN];
          // R07 enables
          en_d    = avs_writedata[EN_LSB +: NIRQ];
          // writing a flag bit as zero clears it
          wclr    = ~avs_writedata[RAW_LSB +: NIRQ];
        end
        OFS_CLR:  wclr = avs_writedata[RAW_LSB +: NIRQ];
        OFS_EN:   en_d = avs_writedata[EN_LSB - EN_LSB +: NIRQ];
        OFS_CFG:  hd_d = avs_writedata[B_HD];
        default:  wclr = '0;
      endcase
    end
    // R05 operation count
    if (op_done) begin
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    // R08 sticky flags, a same-cycle set beats the clear
    raw_d = (raw_q & ~wclr) | done_set;
  end

  // R12 zero reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_q   <= 1'b0;
      rdat_q  <= '0;
      lclr_q  <= 1'b0;
      slave_q <= 1'b0;
      bufen_q <= 1'b0;
      staen_q <= 1'b0;
      hd_q    <= 1'b0;
      en_q    <= '0;
      raw_q   <= '0;
      cnt_q   <= '0;
    end else begin
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
      lclr_q  <= lclr_d;
      slave_q <= slave_d;
      bufen_q <= bufen_d;
      staen_q <= staen_d;
      hd_q    <= hd_d;
      en_q    <= en_d;
      raw_q   <= raw_d;
      cnt_q   <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdat_q;
  assign slave_mode      = slave_q;
  assign spi_miso        = miso_q;
  assign spi_miso_oe     = rd_q & (st_q == S_DATA) & ~f_q.cs_n;
  // R11 gated requests
  assign irq_req         = raw_q & en_q;
  assign irq             = |irq_req;

endmodule : src_core

// ---- sim/src_core_properties.sv ----
// src_core_properties: concurrent checks on the ports of src_core
// assumes it is bound to src_core and sees its ports only
`timescale 1ns/1ps
module src_core_properties
  import src_pkg::*;
(
  input logic            mclk,
  input logic            sys_rst,
  input logic [AW-1:0]   avs_address,
  input logic            avs_read,
  input logic            avs_write,
  input logic [DW-1:0]   avs_writedata,
  input logic [DW-1:0]   avs_readdata,
  input logic            avs_waitrequest,
  input src_pins_t       spi_in,
  input logic            spi_miso,
  input logic            spi_miso_oe,
  input logic            mst_op_done,
  input logic            slave_mode,
  input logic [NIRQ-1:0] irq_req,
  input logic            irq
);
  logic            wr_acc;
  logic            lclr_q, lclr_d;
  logic [NIRQ-1:0] en_q, en_d;
  assign wr_acc = avs_write && !avs_waitrequest;
  // shadow of the enables and line-latch clear, both writable places
  always_comb begin
    lclr_d = lclr_q;
    en_d = en_q;
    if (wr_acc && avs_address == OFS_CTRL) begin
      lclr_d = avs_writedata[B_LCLR];
      en_d = avs_writedata[EN_LSB+:NIRQ];
    end
    if (wr_acc && avs_address == OFS_EN) en_d = avs_writedata[NIRQ-1:0];
    if (sys_rst) begin
      lclr_d = 1'h0;
      en_d = 5'h0;
    end
  end
  always_ff @(posedge mclk) begin
    lclr_q <= lclr_d;
    en_q <= en_d;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_reset_zero: assert property (disable iff (1'h0) sys_rst |=> !slave_mode && !irq)
    else $error("outputs not idle after reset");
  a_role_write: assert property (wr_acc && avs_address == OFS_CTRL |=>
    slave_mode == $past(avs_writedata[B_SLAVE])) else $error("role bit not taken");
  a_role_hold: assert property (!(wr_acc && avs_address == OFS_CTRL) |=> $stable(slave_mode))
    else $error("role changed without a write");
  a_flag_sticky: assert property (|($past(irq_req) & ~irq_req) |-> $past(wr_acc))
    else $error("request dropped without a write");
  a_master_quiet: assert property (!slave_mode && |(irq_req[4:1] & ~$past(irq_req[4:1]))
    |-> $past(wr_acc)) else $error("slave flag rose in master role");
  a_mdone_flag: assert property (mst_op_done && !slave_mode && en_q[I_DONE] |->
    ##[1:2] irq_req[I_DONE]) else $error("done flag missing");
  a_irq_any: assert property (irq == (|irq_req))
    else $error("irq differs from requests");
  a_latch_quiet: assert property (lclr_q && $past(lclr_q) |-> !spi_miso_oe)
    else $error("miso driven while latches cleared");
  a_oe_role: assert property (spi_miso_oe |-> slave_mode)
    else $error("miso driven in master role");
  a_wait_once: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
    !avs_waitrequest) else $error("bus answer timing");
  cover property (mst_op_done);
  cover property ($rose(irq_req[I_BRD]));
  cover property ($rose(spi_miso_oe));
endmodule : src_core_properties

// ---- sim/src_spi_model.sv ----
// src_spi_model: behavioural external spi master on the slave pins
// assumes a 160 ns link clock that stands low between frames
`timescale 1ns/1ps
module src_spi_model
  import src_pkg::*;
(
  output src_pins_t pins,
  input  logic      miso
);
  initial pins = PIN_IDLE;
  task automatic frame(input logic [7:0] cmd, input logic hd, output logic [7:0] got);
    logic [15:0] b;
    int          lo;
    got = 8'h00;
    b = hd ? {cmd, 8'($urandom)} : {8'($urandom), 8'h00};
    lo = hd ? 0 : 8;
    #1.3 pins.cs_n = 1'h0;
    for (int i = 15; i >= lo; i--) begin
      pins.mosi = b[i];
      #80 pins.sck = 1'h1;
      // the data byte of a half-duplex frame is read back on the rising edge
      if (i < 8) got = {got[6:0], miso};
      #80 pins.sck = 1'h0;
    end
    #80 pins.cs_n = 1'h1;
    // released line shows the inverse so a stale value cannot pass
    pins.mosi = ~pins.mosi;
    #80;
  endtask : frame
endmodule : src_spi_model

// ---- sim/src_core_tb.sv ----
// src_core_tb: self-checking bench for the role and interrupt control
// assumes src_spi_model on the pins and the checker bound below
`timescale 1ns/1ps
module src_core_tb;
  import src_pkg::*;
  logic            mclk = 1'h0;
  logic            sys_rst = 1'h1;
  logic [AW-1:0]   avs_address = 8'h0;
  logic            avs_read = 1'h0;
  logic            avs_write = 1'h0;
  logic [DW-1:0]   avs_writedata = 32'h0;
  logic [DW-1:0]   avs_readdata;
  logic            avs_waitrequest;
  src_pins_t       spi_in;
  logic            spi_miso;
  logic [7:0]      got;
  logic            spi_miso_oe;
  logic            mst_op_done = 1'h0;
  logic            slave_mode;
  logic [NIRQ-1:0] irq_req;
  logic            irq;
  int              n_fail = 0;
  int              n_checks = 0;
  int              cyc = 0;
  logic [3:0]      cnt = 4'h0;
  logic [4:0]      raw = 5'h0;
  logic [4:0]      en = 5'h0;
  logic [31:0]     q;
  logic [31:0]     v;
  logic [7:0]      cmds [4] = '{CMD_SWR, CMD_SRD, CMD_BWR, CMD_BRD};
  src_core dut (.*);
  // an undriven miso reads as the inverse so stale data cannot pass
  src_spi_model link (.pins(spi_in), .miso(spi_miso_oe ? spi_miso : ~spi_miso));
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // mid-frame state: a refused command parks in wait, an accepted one shows its direction
  function automatic logic [2:0] exp_state(input logic acc, input logic rd);
    if (!acc) return STC_WAIT;
    return rd ? STC_RD : STC_WR;
  endfunction : exp_state
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // the request stands until an edge samples waitrequest low; read data is taken there
    @(posedge mclk);
    while (avs_waitrequest !== 1'h0) @(posedge mclk);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    // one idle edge so a request never rises in the edge that drops it
    @(posedge mclk);
  endtask : bus
  task automatic ctrl(input logic [31:0] d);
    bus(1'h1, OFS_CTRL, d);
    raw = raw & d[4:0];
    en = d[9:5];
  endtask : ctrl
  task automatic verify(input logic ckst);
    bus(1'h0, OFS_CTRL, 32'h0);
    chk(q[26:23], cnt);
    if (ckst) chk(q[22:20], STC_IDLE);
    chk(q[4:0], raw);
    bus(1'h0, OFS_STAT, 32'h0);
    chk(q[4:0], raw);
    chk(irq_req, raw & en);
    chk(irq, |(raw & en));
  endtask : verify
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(17114));
    repeat (10) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    bus(1'h0, OFS_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, 8'h10, 32'hffffffff);
    bus(1'h0, 8'h10, 32'h0);
    chk(q, 32'h0);
    repeat (4) begin
      v = $urandom & 32'h700003e0;
      ctrl(v);
      bus(1'h0, OFS_CTRL, 32'h0);
      chk(q & 32'h700003e0, v);
    end
    ctrl(32'h00000020);
    mst_op_done <= 1'h1;
    @(posedge mclk);
    mst_op_done <= 1'h0;
    cnt++;
    raw[I_DONE] = 1'h1;
    verify(1'h1);
    bus(1'h1, OFS_CLR, 32'h1);
    raw = 5'h0;
    verify(1'h1);
    bus(1'h1, OFS_CFG, 32'h1);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        ctrl({2'h1, p[0], p[0], 18'h0, 5'h1f, 5'h1f});
        v = {27'h0, raw};
        fork
          link.frame(cmds[i], 1'h1, got);
          begin
            repeat (500) @(posedge mclk);
            bus(1'h0, OFS_CTRL, 32'h0);
          end
        join
        chk(q[22:20], exp_state(p[0], i[0]));
        chk(got, (p == 1 && i[0]) ? v[7:0] : 8'hff);
        @(posedge mclk);
        if (p == 1) begin
          cnt++;
          raw[i+1] = 1'h1;
          raw[I_DONE] = 1'h1;
        end
        verify(p[0]);
      end
    end
    ctrl(32'hf00003e0);
    link.frame(CMD_SWR, 1'h1, got);
    @(posedge mclk);
    verify(1'h1);
    bus(1'h1, OFS_CFG, 32'h0);
    ctrl(32'h400003e0);
    link.frame(8'($urandom), 1'h0, got);
    @(posedge mclk);
    cnt++;
    raw[I_DONE] = 1'h1;
    verify(1'h1);
    // reset again with role, count, enables and the transfer-done flag set
    sys_rst <= 1'h1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    cnt = 4'h0;
    raw = 5'h0;
    en = 5'h0;
    bus(1'h0, OFS_CTRL, 32'h0);
    chk(q, 32'h0);
    verify(1'h1);
    test_done();
  end
endmodule : src_core_tb
bind src_core src_core_properties chk_i (.*);
